// File: src/conv_ctrl_pkg.sv
// Purpose: Shared constants for the dual converter control registers
// Assumes: 8-bit special-function-register bus, one clock
// Notes: Addresses are the documented register locations
package conv_ctrl_pkg;
    localparam logic [7:0] ADDR_CHAN0_LOW = 8'hF9; // Channel 0 low code byte
    localparam logic [7:0] ADDR_CHAN0_HIGH = 8'hFA; // Channel 0 high nibble
    localparam logic [7:0] ADDR_CHAN1_LOW = 8'hFB; // Channel 1 low code byte
    localparam logic [7:0] ADDR_CHAN1_HIGH = 8'hFC; // Channel 1 high nibble
    localparam logic [7:0] ADDR_CONTROL = 8'hFD; // Shared control register
    localparam logic [7:0] CONTROL_RESET = 8'h04; // Control value after reset
    localparam logic [7:0] CODE_RESET = 8'h00; // Data registers after reset
    localparam int BIT_MODE8 = 7; // 1 selects 8-bit mode
    localparam int BIT_RANGE1 = 6; // Channel 1 range select
    localparam int BIT_RANGE0 = 5; // Channel 0 range select
    localparam int BIT_CLEAR1_N = 4; // Channel 1 force zero, active low
    localparam int BIT_CLEAR0_N = 3; // Channel 0 force zero, active low
    localparam int BIT_SYNC = 2; // Immediate update enable
    localparam int BIT_POWER1 = 1; // Channel 1 power on
    localparam int BIT_POWER0 = 0; // Channel 0 power on
endpackage

// File: src/chan_output.sv
// Purpose: One converter channel: live code latch and output conditioning
// Assumes: Load strobes come from the register block on the same clock
// Notes: Stored data is never altered by clear or power-down
`timescale 1ns/1ps
module chan_output (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load, // Copy held code to the live code
    input wire logic [11:0] held_code, // Code assembled from the data pair
    input wire logic force_zero_n, // Low forces output code to zero
    input wire logic power_on, // High enables the output buffer
    output logic [11:0] code, // Code seen by the analog string
    output logic enable // Output buffer enabled, else three-state
);
    logic [11:0] live; // Code last taken by the channel
    logic [11:0] next_live;

    // Next live code: only a load strobe changes it
    always_comb begin
        next_live = live;
        if (load) begin
            next_live = held_code;
        end
    end

    // Register the live code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live <= 12'h000;
        end else begin
            live <= next_live;
        end
    end

    // Clear masks only the output; live code survives for restore
    assign code = force_zero_n ? live : 12'h000;
    assign enable = power_on;

    a_zero_forced: assert property (@(posedge clk) disable iff (!rst_n)
        !force_zero_n |-> code == 12'h000)
        else $error("Cleared channel shows a nonzero code");
    a_live_kept: assert property (@(posedge clk) disable iff (!rst_n)
        !load |=> live == $past(live))
        else $error("Live code changed without a load");
endmodule

// File: src/dual_dac_control_regs.sv
// Purpose: Control and data registers for two 12-bit voltage-output converters
// Assumes: Processor writes and reads by 8-bit address on the processor clock
// Notes: Analog string and buffer lie outside; this block drives codes and enables
`timescale 1ns/1ps
module dual_dac_control_regs (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR, // Register address from the core
    input wire logic [7:0] SFR_WDATA, // Write data
    input wire logic SFR_WR, // One-cycle write strobe
    input wire logic SFR_RD, // Read strobe
    output logic [7:0] SFR_RDATA, // Read data, registered
    output logic SFR_HIT, // Address falls in this block
    output logic [11:0] CHAN0_CODE, // Channel 0 code to the string
    output logic [11:0] CHAN1_CODE, // Channel 1 code to the string
    output logic CHAN0_ENABLE, // Channel 0 buffer on, else three-state
    output logic CHAN1_ENABLE, // Channel 1 buffer on, else three-state
    output logic CHAN0_RANGE_SUPPLY, // Channel 0 full scale is the supply
    output logic CHAN1_RANGE_SUPPLY // Channel 1 full scale is the supply
);
    import conv_ctrl_pkg::*;

    logic [7:0] converter_control; // Shared control register
    logic [7:0] chan0_code_low; // Channel 0 low byte
    logic [7:0] chan0_code_high; // Channel 0 high byte
    logic [7:0] chan1_code_low; // Channel 1 low byte
    logic [7:0] chan1_code_high; // Channel 1 high byte
    logic [7:0] rdata; // Registered read data
    logic [7:0] next_converter_control;
    logic [7:0] next_chan0_code_low;
    logic [7:0] next_chan0_code_high;
    logic [7:0] next_chan1_code_low;
    logic [7:0] next_chan1_code_high;
    logic [7:0] next_rdata;
    logic wr_ctrl; // Write to control register
    logic wr_c0l; // Write to channel 0 low byte
    logic wr_c1l; // Write to channel 1 low byte
    logic sync_rise; // Software sets the sync bit
    logic load0; // Channel 0 takes its held code
    logic load1; // Channel 1 takes its held code
    logic [11:0] held0; // Channel 0 code from its pair
    logic [11:0] held1; // Channel 1 code from its pair

    // Assemble a channel code from its register pair in the current mode
    function automatic logic [11:0] pair_code(input logic mode8, input logic [7:0] lo,
                                              input logic [7:0] hi);
        if (mode8) begin
            pair_code = {4'h0, lo};
        end else begin
            pair_code = {hi[3:0], lo};
        end
    endfunction

    // Address decode for writes at the fixed locations
    assign wr_ctrl = SFR_WR && (SFR_ADDR == ADDR_CONTROL);
    assign wr_c0l = SFR_WR && (SFR_ADDR == ADDR_CHAN0_LOW);
    assign wr_c1l = SFR_WR && (SFR_ADDR == ADDR_CHAN1_LOW);
    assign SFR_HIT = (SFR_ADDR >= ADDR_CHAN0_LOW) && (SFR_ADDR <= ADDR_CONTROL);

    // Register writes; byte-wide only since none are bit addressable
    always_comb begin
        next_converter_control = converter_control;
        next_chan0_code_low = chan0_code_low;
        next_chan0_code_high = chan0_code_high;
        next_chan1_code_low = chan1_code_low;
        next_chan1_code_high = chan1_code_high;
        if (SFR_WR) begin
            unique case (SFR_ADDR)
                ADDR_CHAN0_LOW: next_chan0_code_low = SFR_WDATA;
                ADDR_CHAN0_HIGH: next_chan0_code_high = SFR_WDATA;
                ADDR_CHAN1_LOW: next_chan1_code_low = SFR_WDATA;
                ADDR_CHAN1_HIGH: next_chan1_code_high = SFR_WDATA;
                ADDR_CONTROL: next_converter_control = SFR_WDATA;
                default: begin
                    // Other addresses belong to other peripherals
                end
            endcase
        end
    end

    // Read mux; unmapped addresses return zero
    always_comb begin
        next_rdata = rdata;
        if (SFR_RD) begin
            unique case (SFR_ADDR)
                ADDR_CHAN0_LOW: next_rdata = chan0_code_low;
                ADDR_CHAN0_HIGH: next_rdata = chan0_code_high;
                ADDR_CHAN1_LOW: next_rdata = chan1_code_low;
                ADDR_CHAN1_HIGH: next_rdata = chan1_code_high;
                ADDR_CONTROL: next_rdata = converter_control;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Register state; reset values give powered-down, three-state outputs
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            converter_control <= CONTROL_RESET;
            chan0_code_low <= CODE_RESET;
            chan0_code_high <= CODE_RESET;
            chan1_code_low <= CODE_RESET;
            chan1_code_high <= CODE_RESET;
            rdata <= 8'h00;
        end else begin
            converter_control <= next_converter_control;
            chan0_code_low <= next_chan0_code_low;
            chan0_code_high <= next_chan0_code_high;
            chan1_code_low <= next_chan1_code_low;
            chan1_code_high <= next_chan1_code_high;
            rdata <= next_rdata;
        end
    end

    assign SFR_RDATA = rdata;

    // Update control: low-byte writes load at once only while sync is set.
    // The load uses the written byte directly, so the output tracks the same edge.
    assign sync_rise = wr_ctrl && SFR_WDATA[BIT_SYNC] && !converter_control[BIT_SYNC];
    assign load0 = (wr_c0l && converter_control[BIT_SYNC]) || sync_rise;
    assign load1 = (wr_c1l && converter_control[BIT_SYNC]) || sync_rise;
    // Held codes look ahead at the incoming write so the load takes fresh data.
    // Software writes the high byte first, else a stale nibble escapes
    assign held0 = pair_code(wr_ctrl ? SFR_WDATA[BIT_MODE8] : converter_control[BIT_MODE8],
                             next_chan0_code_low, chan0_code_high);
    assign held1 = pair_code(wr_ctrl ? SFR_WDATA[BIT_MODE8] : converter_control[BIT_MODE8],
                             next_chan1_code_low, chan1_code_high);

    // Channel 0 output stage
    chan_output chan0 (
        .clk(CLK),
        .rst_n(RST_N),
        .load(load0),
        .held_code(held0),
        .force_zero_n(converter_control[BIT_CLEAR0_N]),
        .power_on(converter_control[BIT_POWER0]),
        .code(CHAN0_CODE),
        .enable(CHAN0_ENABLE)
    );

    // Channel 1 output stage
    chan_output chan1 (
        .clk(CLK),
        .rst_n(RST_N),
        .load(load1),
        .held_code(held1),
        .force_zero_n(converter_control[BIT_CLEAR1_N]),
        .power_on(converter_control[BIT_POWER1]),
        .code(CHAN1_CODE),
        .enable(CHAN1_ENABLE)
    );

    // Range selects go straight to the analog switches
    assign CHAN0_RANGE_SUPPLY = converter_control[BIT_RANGE0];
    assign CHAN1_RANGE_SUPPLY = converter_control[BIT_RANGE1];

    // Named steps of a synchronous update
    sequence s_hold_write;
        wr_c0l && !converter_control[BIT_SYNC];
    endsequence
    sequence s_sync_set;
        sync_rise;
    endsequence

    a_hold_no_update: assert property (@(posedge CLK) disable iff (!RST_N)
        s_hold_write and !sync_rise |=> CHAN0_CODE == $past(CHAN0_CODE))
        else $error("Held write reached channel 0 output");
    a_sync_both_load: assert property (@(posedge CLK) disable iff (!RST_N)
        s_sync_set |-> load0 && load1)
        else $error("Sync set did not load both channels");
    a_immediate_load: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_c1l && converter_control[BIT_SYNC] && converter_control[BIT_CLEAR1_N]
        && !wr_ctrl |=> CHAN1_CODE[7:0] == $past(SFR_WDATA))
        else $error("Immediate write not seen on channel 1");
    a_mode8_upper: assert property (@(posedge CLK) disable iff (!RST_N)
        converter_control[BIT_MODE8] && !wr_ctrl && load0 |=> CHAN0_CODE[11:8] == 4'h0)
        else $error("8-bit mode leaked upper bits");
    a_power_enable: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_ctrl |=> CHAN0_ENABLE == $past(SFR_WDATA[BIT_POWER0])
                    && CHAN1_ENABLE == $past(SFR_WDATA[BIT_POWER1]))
        else $error("Enables do not follow power bits");
    a_range_follow: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_ctrl |=> CHAN1_RANGE_SUPPLY == $past(SFR_WDATA[BIT_RANGE1])
                    && CHAN0_RANGE_SUPPLY == $past(SFR_WDATA[BIT_RANGE0]))
        else $error("Range selects do not follow control");
    a_ctrl_readback: assert property (@(posedge CLK) disable iff (!RST_N)
        SFR_RD && SFR_ADDR == ADDR_CONTROL |=> SFR_RDATA == $past(converter_control))
        else $error("Control readback wrong");
    a_data_readback: assert property (@(posedge CLK) disable iff (!RST_N)
        SFR_RD && SFR_ADDR == ADDR_CHAN1_HIGH |=> SFR_RDATA == $past(chan1_code_high))
        else $error("Data readback wrong");
    a_clear_keeps: assert property (@(posedge CLK) disable iff (!RST_N)
        !SFR_WR |=> chan0_code_low == $past(chan0_code_low))
        else $error("Stored code changed without a write");
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the dual converter control registers
// Assumes: Bus driven at the falling edge, sampled by the design at the rising edge
// Notes: Table rows cover the register map; hand tests cover update, clear and reset
`timescale 1ns/1ps
module tb_top;
    import conv_ctrl_pkg::*;
    typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp; logic hit;} row_t;
    logic CLK = 1'b0; // Processor clock, 100 ns period
    logic RST_N = 1'b0; // Held low for the first 20 cycles
    logic [7:0] SFR_ADDR = 8'h00; // Register address
    logic [7:0] SFR_WDATA = 8'h00; // Write data
    logic SFR_WR = 1'b0; // Write strobe
    logic SFR_RD = 1'b0; // Read strobe
    logic [7:0] SFR_RDATA; // Registered read data
    logic SFR_HIT; // Address decode
    logic [11:0] CHAN0_CODE; // Live code, channel 0
    logic [11:0] CHAN1_CODE; // Live code, channel 1
    logic CHAN0_ENABLE; // Buffer enables
    logic CHAN1_ENABLE;
    logic CHAN0_RANGE_SUPPLY; // Range selects
    logic CHAN1_RANGE_SUPPLY;
    int failures = 0; // Mismatch count
    int n_compared = 0; // Comparison count
    // Map rows: written value, read-back value and decode; unmapped places read 00
    row_t rows [7] = '{
        '{ADDR_CHAN0_HIGH, 8'h0C, 8'h0C, 1'b1}, '{ADDR_CHAN0_LOW, 8'hA5, 8'hA5, 1'b1},
        '{ADDR_CHAN1_HIGH, 8'h07, 8'h07, 1'b1}, '{ADDR_CHAN1_LOW, 8'h5A, 8'h5A, 1'b1},
        '{ADDR_CONTROL, 8'h64, 8'h64, 1'b1}, '{8'hF8, 8'hFF, 8'h00, 1'b0},
        '{8'hFE, 8'hFF, 8'h00, 1'b0}};

    dual_dac_control_regs dut (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
        .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
        .SFR_HIT(SFR_HIT), .CHAN0_CODE(CHAN0_CODE), .CHAN1_CODE(CHAN1_CODE),
        .CHAN0_ENABLE(CHAN0_ENABLE), .CHAN1_ENABLE(CHAN1_ENABLE),
        .CHAN0_RANGE_SUPPLY(CHAN0_RANGE_SUPPLY), .CHAN1_RANGE_SUPPLY(CHAN1_RANGE_SUPPLY));

    // Free-running clock
    initial forever #50 CLK = ~CLK;

    // Single comparison point; four-state compare so X never matches
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe; the strobe drops a full cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1'b1;
        @(negedge CLK);
        SFR_WR = 1'b0;
    endtask

    // Read, then look at the registered data once it has been captured
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLK);
        SFR_ADDR = a;
        SFR_RD = 1'b1;
        @(negedge CLK);
        SFR_RD = 1'b0;
        @(negedge CLK);
        chk({4'h0, SFR_RDATA}, {4'h0, e});
    endtask

    // Let the write land, then compare codes and flags {en1, en0, chan1_range_select, chan0_range_select}
    task automatic outs(input logic [11:0] c0, input logic [11:0] c1, input logic [3:0] f);
        @(negedge CLK);
        chk(CHAN0_CODE, c0);
        chk(CHAN1_CODE, c1);
        chk({8'h00, CHAN1_ENABLE, CHAN0_ENABLE, CHAN1_RANGE_SUPPLY, CHAN0_RANGE_SUPPLY},
            {8'h00, f});
    endtask

    // Verdict, reached from the main sequence or the watchdog
    task automatic conclude;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 400 cycles
    initial begin
        repeat (3000) @(posedge CLK);
        failures++;
        conclude();
    end

    // Main sequence
    initial begin
        repeat (20) @(negedge CLK);
        RST_N = 1'b1;
        foreach (rows[i]) begin
            @(negedge CLK);
            SFR_ADDR = rows[i].addr;
            #1 chk({11'h0, SFR_HIT}, {11'h0, rows[i].hit});
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rexp);
        end
        $display("test done: register map");
        // High-then-low writes loaded CA5 and 75A while clears were low; codes come back
        wr(ADDR_CONTROL, 8'h1F);
        outs(12'hCA5, 12'h75A, 4'b1100);
        wr(ADDR_CHAN0_HIGH, 8'h0B);
        outs(12'hCA5, 12'h75A, 4'b1100);
        wr(ADDR_CHAN0_LOW, 8'hCD);
        wr(ADDR_CHAN1_HIGH, 8'h0F);
        wr(ADDR_CHAN1_LOW, 8'h21);
        outs(12'hBCD, 12'hF21, 4'b1100);
        $display("test done: immediate update");
        // Clear and power bits only mask, ranges follow bits 6 and 5
        wr(ADDR_CONTROL, 8'h6D);
        outs(12'hBCD, 12'h000, 4'b0111);
        wr(ADDR_CONTROL, 8'h57);
        outs(12'h000, 12'hF21, 4'b1110);
        $display("test done: clear and power");
        // Held writes must not leak; setting sync loads both together
        wr(ADDR_CONTROL, 8'h1B);
        wr(ADDR_CHAN0_LOW, 8'h11);
        wr(ADDR_CHAN0_HIGH, 8'h02);
        wr(ADDR_CHAN1_LOW, 8'h33);
        wr(ADDR_CHAN1_HIGH, 8'h04);
        outs(12'hBCD, 12'hF21, 4'b1100);
        wr(ADDR_CONTROL, 8'h1F);
        outs(12'h211, 12'h433, 4'b1100);
        $display("test done: synchronous update");
        // 8-bit mode: the high register must not matter, code is right-justified
        wr(ADDR_CONTROL, 8'h9F);
        wr(ADDR_CHAN0_HIGH, 8'h0F);
        wr(ADDR_CHAN0_LOW, 8'hE7);
        @(negedge CLK);
        chk(CHAN0_CODE, 12'h0E7);
        // Sync set together with 12-bit mode: both load full pairs in the new mode
        wr(ADDR_CONTROL, 8'h9B);
        wr(ADDR_CHAN1_LOW, 8'h44);
        outs(12'h0E7, 12'h433, 4'b1100);
        wr(ADDR_CONTROL, 8'h1F);
        outs(12'hFE7, 12'h444, 4'b1100);
        $display("test done: 8-bit mode");
        // Reset in mid-run: outputs fall at once, registers return to defaults
        @(negedge CLK);
        RST_N = 1'b0;
        outs(12'h000, 12'h000, 4'b0000);
        RST_N = 1'b1;
        rd(ADDR_CONTROL, CONTROL_RESET);
        for (int a = 8'hF9; a <= 8'hFC; a++) begin
            rd(a[7:0], CODE_RESET);
        end
        $display("test done: reset");
        conclude();
    end
endmodule
